//--- pxe_pkg.sv
package pxe_pkg;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam int unsigned PXE_BYTE_BITS = 8;
  localparam logic [3:0]  PXE_BIT_LAST  = 4'h8;

  // Upper four slave-address bits; the low three come from the pins
  localparam logic [3:0]  PXE_PORT_ADDR_HI = 4'h4;
  localparam logic [3:0]  PXE_MEM_ADDR_HI  = 4'hA;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  PXE_PORT_RESET = 8'hFF;
  localparam logic [9:0]  PXE_ADDR_RESET = 10'h000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned PXE_CLK_PERIOD_NS = 5;
  localparam int unsigned PXE_WR_TIME_NS    = 5000000;
  localparam int unsigned PXE_WR_CYCLES     =
    PXE_WR_TIME_NS / PXE_CLK_PERIOD_NS;
  localparam int unsigned PXE_WR_CNT_W      = 20;

  // ----------------------------------------------------------------
  // Link states, Gray coded along the write paths
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PXE_IDLE    = 4'h0,
    PXE_DEVADR  = 4'h1,
    PXE_DEVACK  = 4'h3,
    PXE_WADR    = 4'h2,
    PXE_WADRACK = 4'h6,
    PXE_WDAT    = 4'h7,
    PXE_WDATACK = 4'h5,
    PXE_RDAT    = 4'h4,
    PXE_RACK    = 4'hC,
    PXE_IGNORE  = 4'hD
  } pxe_state_type;

endpackage : pxe_pkg

//--- pxe_sync.sv
`timescale 1ns/1ps
module pxe_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser, one per bit
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // First stage feeds only the second; nothing else reads it
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          meta_r[i]   <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta_r[i]   <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule : pxe_sync

//--- pxe_top.sv
`timescale 1ns/1ps
module pxe_top
  import pxe_pkg::*;
#(
  parameter int unsigned WR_CYCLES = PXE_WR_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [2:0] device_select_pins,
  input  wire logic       write_guard_pin,
  input  wire logic [3:0] port_pins_low_nibble_in,
  input  wire logic [3:0] port_pins_high_nibble_in,
  output logic      [3:0] port_pins_low_nibble_out,
  output logic      [3:0] port_pins_high_nibble_out,
  output logic      [3:0] port_pins_low_nibble_oe,
  output logic      [3:0] port_pins_high_nibble_oe,
  output logic      [3:0] port_pins_low_nibble_pu,
  output logic      [3:0] port_pins_high_nibble_pu,
  output logic            mem_busy
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [13:0] raw_in;
  logic [13:0] sync_in;
  logic        scl_s;
  logic        sda_s;
  logic [2:0]  sel_s;
  logic        guard_s;
  logic [7:0]  pins_s;

  assign raw_in = {scl_in, sda_in, device_select_pins, write_guard_pin,
                   port_pins_high_nibble_in, port_pins_low_nibble_in};

  pxe_sync #(
    .WIDTH (14)
  ) u_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in (raw_in),
    .sync_out (sync_in)
  );

  assign scl_s   = sync_in[13];
  assign sda_s   = sync_in[12];
  assign sel_s   = sync_in[11:9];
  assign guard_s = sync_in[8];
  assign pins_s  = sync_in[7:0];

  // ----------------------------------------------------------------
  // Edge and condition detection
  // ----------------------------------------------------------------
  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  // Data moving under a high clock is never a data bit
  assign start_c  = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_c   = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // ----------------------------------------------------------------
  // Link state
  // ----------------------------------------------------------------
  pxe_state_type state_r;
  logic [3:0]    bit_cnt_r;
  logic [7:0]    rx_sr_r;
  logic [7:0]    tx_r;
  logic          sda_oe_r;
  logic          is_mem_r;
  logic          rw_r;
  logic          port_wr_p_r;
  logic          mem_adr_p_r;
  logic          mem_dat_p_r;
  logic          mem_rd_p_r;
  logic          wr_stop_p_r;
  logic          busy_r;
  logic [7:0]    mem_rdata;
  logic [7:0]    tx_nxt;
  logic          port_hit;
  logic          mem_hit;

  assign port_hit = rx_sr_r[7:1] == {PXE_PORT_ADDR_HI, sel_s};
  assign mem_hit  = rx_sr_r[7:1] == {PXE_MEM_ADDR_HI, sel_s};
  // Port reads sample the pins at the edge that starts the byte
  assign tx_nxt   = is_mem_r ? mem_rdata : pins_s;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r     <= PXE_IDLE;
      bit_cnt_r   <= 4'h0;
      rx_sr_r     <= 8'h00;
      tx_r        <= 8'hFF;
      sda_oe_r    <= 1'b0;
      is_mem_r    <= 1'b0;
      rw_r        <= 1'b0;
      port_wr_p_r <= 1'b0;
      mem_adr_p_r <= 1'b0;
      mem_dat_p_r <= 1'b0;
      mem_rd_p_r  <= 1'b0;
      wr_stop_p_r <= 1'b0;
    end else begin
      port_wr_p_r <= 1'b0;
      mem_adr_p_r <= 1'b0;
      mem_dat_p_r <= 1'b0;
      mem_rd_p_r  <= 1'b0;
      wr_stop_p_r <= 1'b0;
      if (start_c) begin
        // Also a repeated start; the master keeps nine clocks first
        state_r   <= PXE_DEVADR;
        bit_cnt_r <= 4'h0;
        sda_oe_r  <= 1'b0;
      end else if (stop_c) begin
        state_r     <= PXE_IDLE;
        sda_oe_r    <= 1'b0;
        wr_stop_p_r <= is_mem_r & ~rw_r &
                       (state_r == PXE_WDAT ||
                        state_r == PXE_WDATACK);
      end else begin
        case (state_r)
          PXE_IDLE: begin
          end
          PXE_DEVADR, PXE_WADR, PXE_WDAT: begin
            if (scl_rise && bit_cnt_r != PXE_BIT_LAST) begin
              rx_sr_r   <= {rx_sr_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == PXE_BIT_LAST) begin
              sda_oe_r <= 1'b1;
              case (state_r)
                PXE_DEVADR: begin
                  rw_r <= rx_sr_r[0];
                  if (port_hit) begin
                    is_mem_r <= 1'b0;
                    state_r  <= PXE_DEVACK;
                  end else if (mem_hit && !busy_r) begin
                    is_mem_r <= 1'b1;
                    state_r  <= PXE_DEVACK;
                  end else begin
                    // Memory stays silent while programming
                    sda_oe_r <= 1'b0;
                    state_r  <= PXE_IGNORE;
                  end
                end
                PXE_WADR: begin
                  mem_adr_p_r <= 1'b1;
                  state_r     <= PXE_WADRACK;
                end
                default: begin
                  mem_dat_p_r <= is_mem_r;
                  port_wr_p_r <= ~is_mem_r;
                  state_r     <= PXE_WDATACK;
                end
              endcase
            end
          end
          PXE_DEVACK, PXE_WADRACK, PXE_WDATACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (state_r == PXE_DEVACK && rw_r) begin
                tx_r       <= tx_nxt;
                sda_oe_r   <= ~tx_nxt[7];
                mem_rd_p_r <= is_mem_r;
                state_r    <= PXE_RDAT;
              end else begin
                sda_oe_r <= 1'b0;
                if (state_r == PXE_DEVACK && is_mem_r) begin
                  state_r <= PXE_WADR;
                end else begin
                  state_r <= PXE_WDAT;
                end
              end
            end
          end
          PXE_RDAT: begin
            if (scl_rise && bit_cnt_r != PXE_BIT_LAST) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == PXE_BIT_LAST) begin
                sda_oe_r <= 1'b0;
                state_r  <= PXE_RACK;
              end else begin
                sda_oe_r <= ~tx_r[3'(3'd7 - bit_cnt_r[2:0])];
              end
            end
          end
          PXE_RACK: begin
            if (scl_rise && sda_s) begin
              // No acknowledge: keep data released for the stop
              state_r <= PXE_IGNORE;
            end else if (scl_fall) begin
              bit_cnt_r  <= 4'h0;
              tx_r       <= tx_nxt;
              sda_oe_r   <= ~tx_nxt[7];
              mem_rd_p_r <= is_mem_r;
              state_r    <= PXE_RDAT;
            end
          end
          PXE_IGNORE: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            state_r  <= PXE_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Quasi-bidirectional port
  // ----------------------------------------------------------------
  logic [7:0] port_r;
  logic [7:0] port_oe_r;
  logic [7:0] port_pu_r;

  // No direction register: a zero pulls low, a one only pulls up
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      port_r    <= PXE_PORT_RESET;
      port_oe_r <= ~PXE_PORT_RESET;
    end else if (port_wr_p_r) begin
      port_r    <= rx_sr_r;
      port_oe_r <= ~rx_sr_r;
    end
  end

  // Strong pull-up only for the edge; weak source holds the level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      port_pu_r <= 8'h00;
    end else if (port_wr_p_r) begin
      port_pu_r <= rx_sr_r;
    end else if (scl_fall) begin
      port_pu_r <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Memory, address counter and page buffer
  // ----------------------------------------------------------------
  logic [7:0] mem_r [256];
  logic [7:0] page_r [4];
  logic [3:0] page_vld_r;
  logic [7:0] addr_cnt_r;
  logic       commit;

  assign mem_rdata = mem_r[addr_cnt_r];
  // Guard pin high keeps the array untouched; bytes are still acked
  assign commit    = wr_stop_p_r & (|page_vld_r) & ~guard_s;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_cnt_r <= PXE_ADDR_RESET[7:0];
      page_vld_r <= 4'h0;
    end else if (mem_adr_p_r) begin
      addr_cnt_r <= rx_sr_r;
      page_vld_r <= 4'h0;
    end else if (mem_dat_p_r) begin
      page_r[addr_cnt_r[1:0]]     <= rx_sr_r;
      page_vld_r[addr_cnt_r[1:0]] <= 1'b1;
      // Only the low two bits step, so a fifth byte wraps in place
      addr_cnt_r[1:0] <= addr_cnt_r[1:0] + 2'h1;
    end else if (mem_rd_p_r) begin
      addr_cnt_r <= addr_cnt_r + 8'h01;
    end else if (wr_stop_p_r) begin
      page_vld_r <= 4'h0;
    end
  end

  // Page lands in the array at the stop; the timer then holds off
  always_ff @(posedge clk_sys) begin
    if (commit) begin
      for (int k = 0; k < 4; k++) begin
        if (page_vld_r[k]) begin
          mem_r[{addr_cnt_r[7:2], 2'(k)}] <= page_r[k];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-timed programming cycle
  // ----------------------------------------------------------------
  logic [PXE_WR_CNT_W-1:0] wr_cnt_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_r   <= 1'b0;
      wr_cnt_r <= '0;
    end else if (commit) begin
      busy_r   <= 1'b1;
      wr_cnt_r <= PXE_WR_CNT_W'(WR_CYCLES - 1);
    end else if (busy_r) begin
      if (wr_cnt_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        wr_cnt_r <= wr_cnt_r - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic sda_out_r;
  logic [7:0] pins_out_r;

  // Open drain: the driven level is always low
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sda_out_r  <= 1'b0;
      pins_out_r <= 8'h00;
    end else begin
      sda_out_r  <= 1'b0;
      pins_out_r <= 8'h00;
    end
  end

  assign sda_out                   = sda_out_r;
  assign sda_oe                    = sda_oe_r;
  assign port_pins_low_nibble_out  = pins_out_r[3:0];
  assign port_pins_high_nibble_out = pins_out_r[7:4];
  assign port_pins_low_nibble_oe   = port_oe_r[3:0];
  assign port_pins_high_nibble_oe  = port_oe_r[7:4];
  assign port_pins_low_nibble_pu   = port_pu_r[3:0];
  assign port_pins_high_nibble_pu  = port_pu_r[7:4];
  assign mem_busy                  = busy_r;

endmodule : pxe_top

//--- pxe_checker.sv
`timescale 1ns/1ps
module pxe_checker #(
  parameter int unsigned WR_CYCLES = 50
) (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [3:0] port_pins_low_nibble_out,
  input wire logic [3:0] port_pins_high_nibble_out,
  input wire logic [3:0] port_pins_low_nibble_oe,
  input wire logic [3:0] port_pins_high_nibble_oe,
  input wire logic [3:0] port_pins_low_nibble_pu,
  input wire logic [3:0] port_pins_high_nibble_pu,
  input wire logic       mem_busy
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [7:0]  oe_all;
  logic [7:0]  pu_all;
  logic [19:0] busy_cnt_r;
  logic [3:0]  stop_age_r;
  logic        sda_d_r;
  logic        stop_seen;
  assign oe_all    = {port_pins_high_nibble_oe, port_pins_low_nibble_oe};
  assign pu_all    = {port_pins_high_nibble_pu, port_pins_low_nibble_pu};
  assign stop_seen = scl_in && sda_in && !sda_d_r;
  always_ff @(posedge clk_sys) begin
    sda_d_r <= sda_in;
  end
  always_ff @(posedge clk_sys) begin
    if (srst || !mem_busy) busy_cnt_r <= 20'h00000;
    else busy_cnt_r <= busy_cnt_r + 20'h00001;
  end
  // Saturating age, so a busy flag with no recent stop is caught
  always_ff @(posedge clk_sys) begin
    if (srst) stop_age_r <= 4'hF;
    else if (stop_seen) stop_age_r <= 4'h0;
    else if (stop_age_r != 4'hF) stop_age_r <= stop_age_r + 4'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_sda_od;
    sda_out == 1'b0;
  endproperty
  a_sda_od: assert property (p_sda_od)
    else $error("data line driven high");
  property p_port_od;
    {port_pins_high_nibble_out, port_pins_low_nibble_out} == 8'h00;
  endproperty
  a_port_od: assert property (p_port_od)
    else $error("port pin driven high");
  property p_pu_excl;
    (pu_all & oe_all) == 8'h00;
  endproperty
  a_pu_excl: assert property (p_pu_excl)
    else $error("pull-up on a pin pulled low");
  property p_pu_off;
    (pu_all != 8'h00 && $fell(scl_in)) |-> ##[1:8] pu_all == 8'h00;
  endproperty
  a_pu_off: assert property (p_pu_off)
    else $error("strong pull-up kept past clock fall");
  property p_sda_hold;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_hold: assert property (p_sda_hold)
    else $error("data drive changed while clock high");
  property p_rst_vals;
    $fell(srst) |-> !sda_oe && oe_all == 8'h00 && pu_all == 8'h00
      && !mem_busy;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs wrong after reset");
  property p_busy_len;
    $fell(mem_busy) |-> busy_cnt_r == 20'(WR_CYCLES);
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("programming time wrong");
  property p_busy_cause;
    $rose(mem_busy) |-> stop_age_r < 4'hA;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without a stop");
  property p_stop_rel;
    stop_seen |=> !sda_oe [*8];
  endproperty
  a_stop_rel: assert property (p_stop_rel)
    else $error("data driven after stop");
endmodule : pxe_checker

bind pxe_top pxe_checker #(.WR_CYCLES(WR_CYCLES)) i_chk (.*);

//--- pxe_i2c_master.sv
`timescale 1ns/1ps
module pxe_i2c_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // ----------------------------------------------------------------
  // Serial master, 48 ns bit time, clock still between frames
  // ----------------------------------------------------------------
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves 6 ns into the low phase to keep clear of the fall
  task automatic bit_io(input logic b, output logic r);
    #6 sda_low = ~b;
    #18 scl = 1'b1;
    #12 r = sda;
    #12 scl = 1'b0;
  endtask : bit_io
  task automatic start;
    #6 sda_low = 1'b0;
    #18 scl = 1'b1;
    #24 sda_low = 1'b1;
    #24 scl = 1'b0;
  endtask : start
  task automatic stop;
    #6 sda_low = 1'b1;
    #18 scl = 1'b1;
    #24 sda_low = 1'b0;
    #24;
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  task automatic rd_byte(input logic ack, output logic [7:0] d,
                         output logic rel);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, rel);
  endtask : rd_byte
endmodule : pxe_i2c_master

//--- pxe_top_tb_top.sv
`timescale 1ns/1ps
module pxe_top_tb_top;
  import pxe_pkg::*;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  localparam int unsigned WR_N = 400;
  logic       clk_sys      = 1'b0;
  logic       srst         = 1'b1;
  logic       scl;
  logic       sda_low;
  logic       sda;
  logic [2:0] sel          = 3'h5;
  logic [7:0] ext_low      = 8'h00;
  logic [7:0] pins;
  logic [7:0] pu_seen      = 8'h00;
  logic       sda_out, sda_oe, busy;
  logic [3:0] lo_out, hi_out, lo_oe, hi_oe, lo_pu, hi_pu;
  int         err_total    = 0;
  int         total_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  // Open drain: any party pulling low wins, weak pull-ups otherwise
  assign sda  = ~(sda_low | (sda_oe & ~sda_out));
  assign pins = ~(({hi_oe, lo_oe} & ~{hi_out, lo_out}) | ext_low);
  always @(posedge clk_sys) begin
    if ({hi_pu, lo_pu} != 8'h00) pu_seen <= {hi_pu, lo_pu};
  end
  pxe_top #(.WR_CYCLES(WR_N)) i_dut (
    .clk_sys(clk_sys), .srst(srst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .device_select_pins(sel),
    .write_guard_pin(1'b0), .port_pins_low_nibble_in(pins[3:0]),
    .port_pins_high_nibble_in(pins[7:4]),
    .port_pins_low_nibble_out(lo_out), .port_pins_high_nibble_out(hi_out),
    .port_pins_low_nibble_oe(lo_oe), .port_pins_high_nibble_oe(hi_oe),
    .port_pins_low_nibble_pu(lo_pu), .port_pins_high_nibble_pu(hi_pu),
    .mem_busy(busy));
  pxe_i2c_master i_mst (.scl(scl), .sda_low(sda_low), .sda(sda));
  // ----------------------------------------------------------------
  // Checks and scenarios
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic t_port_wr(input logic [7:0] d);
    logic a;
    i_mst.start();
    i_mst.wr_byte({PXE_PORT_ADDR_HI, sel, 1'b0}, a);
    chk_bit(a, 1'b1);
    i_mst.wr_byte(d, a);
    chk_bit(a, 1'b1);
    chk_byte(pins, d);
    i_mst.stop();
    chk_byte(pu_seen, d);
    chk_byte({hi_pu, lo_pu}, 8'h00);
  endtask : t_port_wr
  task automatic t_port_rd;
    logic       a;
    logic       r;
    logic [7:0] d;
    @(posedge clk_sys);
    #0.5 ext_low = 8'h96;
    i_mst.start();
    i_mst.wr_byte({PXE_PORT_ADDR_HI, sel, 1'b1}, a);
    chk_bit(a, 1'b1);
    i_mst.rd_byte(1'b1, d, r);
    chk_byte(d, 8'h69);
    i_mst.rd_byte(1'b0, d, r);
    chk_byte(d, 8'h69);
    chk_bit(r, 1'b1);
    i_mst.stop();
    ext_low = 8'h00;
  endtask : t_port_rd
  task automatic t_sel;
    logic a;
    for (int s = 0; s < 8; s++) begin
      i_mst.start();
      i_mst.wr_byte({PXE_PORT_ADDR_HI, 3'(s), 1'b0}, a);
      chk_bit(a, s == 5);
      i_mst.stop();
    end
  endtask : t_sel
  task automatic t_mem;
    logic       a;
    logic       r;
    logic [7:0] d;
    int         n;
    i_mst.start();
    i_mst.wr_byte({PXE_MEM_ADDR_HI, sel, 1'b0}, a);
    chk_bit(a, 1'b1);
    i_mst.wr_byte(8'h7E, a);
    chk_bit(a, 1'b1);
    for (int i = 1; i <= 5; i++) begin
      i_mst.wr_byte(8'(8'h11 * i), a);
      chk_bit(a, 1'b1);
    end
    i_mst.stop();
    repeat (10) @(posedge clk_sys);
    #0.5 chk_bit(busy, 1'b1);
    i_mst.start();
    i_mst.wr_byte({PXE_PORT_ADDR_HI, sel, 1'b0}, a);
    chk_bit(a, 1'b1);
    i_mst.start();
    i_mst.wr_byte({PXE_MEM_ADDR_HI, sel, 1'b0}, a);
    chk_bit(a, 1'b0);
    i_mst.stop();
    n = 0;
    while (busy !== 1'b0 && n < WR_N) begin
      @(posedge clk_sys);
      #0.5 n++;
    end
    chk_bit(busy, 1'b0);
    i_mst.start();
    i_mst.wr_byte({PXE_MEM_ADDR_HI, sel, 1'b1}, a);
    i_mst.rd_byte(1'b0, d, r);
    chk_byte(d, 8'h22);
    i_mst.stop();
    i_mst.start();
    i_mst.wr_byte({PXE_MEM_ADDR_HI, sel, 1'b0}, a);
    i_mst.wr_byte(8'h7C, a);
    i_mst.start();
    i_mst.wr_byte({PXE_MEM_ADDR_HI, sel, 1'b1}, a);
    chk_bit(a, 1'b1);
    for (int i = 0; i < 3; i++) begin
      i_mst.rd_byte(i < 2, d, r);
      chk_byte(d, 8'(8'h33 + 8'h11 * i));
    end
    i_mst.stop();
  endtask : t_mem
  initial begin
    repeat (10) @(posedge clk_sys);
    #0.5 srst = 1'b0;
    repeat (5) @(posedge clk_sys);
    // Half-step offset keeps link edges off the sampling clock edge
    #0.5 chk_byte(pins, PXE_PORT_RESET);
    chk_byte({hi_pu, lo_pu}, 8'h00);
    chk_bit(busy, 1'b0);
    t_port_wr(8'h5A);
    t_port_wr(8'hFF);
    t_port_rd();
    t_sel();
    t_mem();
    print_verdict();
  end
  // Whole run needs about 17 us of link traffic
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule : pxe_top_tb_top
